/* src/srpc_core.sv */
`timescale 1ns/1ps
`include "srpc_params.svh"

// Summary of operation
// R01: Auto refresh: strobes low, write high, enable high
// R02: One refresh per auto refresh command
// R03: Internal row counter advances each refresh
// R04: Controller refreshes 4096 rows per 64ms
// R05: Refresh lasts row cycle; only no-ops then
// R06: Auto refresh only when idle, not powered down
// R07: Wait precharge time between auto refreshes
// R08: Self refresh: strobes low, enable sampled low
// R09: In self refresh only clock enable matters
// R10: Self refresh times refreshes internally, indefinitely
// R11: Exit self refresh: clock, then enable high
// R12: After exit, no-ops for row cycle time
// R13: Burst refresh around self refresh recommended
// R14: Enable low mid-burst freezes internal clock
// R15: Enable low when idle enters power-down
// R16: Suspend or power-down under 64ms
// R17: Enable high restarts clock, re-enables buffers
// R18: After power-down exit wait one cycle
// R19: Write mask high blocks that byte lane
// R20: Read mask high disables that lane output
// R21: Chip select high ignores all command inputs
// R22: No-operation starts nothing new
// R23: Data bus undriven in self refresh, power-down
module srpc_core
	import srpc_pkg::*;
#(
	parameter int LANES = `SRPC_LANES,
	parameter int ROW_W = `SRPC_ROW_W,
	parameter int SREF_INT_CYC = `SRPC_SREF_INT_CYC
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic cke_i,
	input wire logic burst_active_i,
	input wire logic read_cycle_i,
	input wire logic write_cycle_i,
	input wire logic [LANES-1:0] dqm_i,
	output logic [LANES-1:0] dq_oe_o,
	output logic [LANES-1:0] wr_lane_en_o,
	output logic int_clk_en_o,
	output logic in_buf_en_o,
	output logic refresh_pulse_o,
	output logic [ROW_W-1:0] refresh_row_o,
	output logic self_refresh_o,
	output logic power_down_o,
	output logic refresh_busy_o
);

	typedef struct packed {
		srpc_state_t st;
		logic [`SRPC_CNT_W-1:0] timer;
		logic [ROW_W-1:0] row;
		logic cke_prev;
		logic suspend;
		logic pulse;
		logic [LANES-1:0] oe;
		logic [LANES-1:0] wen;
		logic clk_en;
		logic buf_en;
		logic sref;
		logic pdwn;
		logic busy;
	} srpc_regs_t;

	srpc_regs_t q, d;
	srpc_cmd_if cif();

	assign cif.cs_n = cs_n_i;
	assign cif.ras_n = ras_n_i;
	assign cif.cas_n = cas_n_i;
	assign cif.we_n = we_n_i;
	assign cif.cke = cke_i;

	srpc_cmd_dec u_dec (
		.c(cif)
	);

	localparam logic [`SRPC_CNT_W-1:0] TRC_CYC = `SRPC_CNT_W'(`SRPC_TRC_CYC);
	// Reload one short: the cycle spent at zero is part of the interval
	localparam logic [`SRPC_CNT_W-1:0] SREF_RELOAD = `SRPC_CNT_W'(SREF_INT_CYC - 1);

	// Self refresh and power-down both shut the input buffers
	function automatic logic is_low_power(input srpc_state_t s);
		return (s == SRPC_SREF) || (s == SRPC_PDWN);
	endfunction

	// =========================================
	// Next state
	always_comb begin
		d = q;
		d.pulse = 1'b0;
		d.cke_prev = cke_i;
		if (q.timer != '0) begin
			d.timer = q.timer - `SRPC_CNT_W'(1);
		end
		case (q.st)
			SRPC_IDLE: begin
				// Clock enable was high last cycle, so this command is live
				if (q.cke_prev && !q.suspend) begin
					if (cif.cmd == SRPC_CMD_AREF) begin
						d.st = SRPC_AREF; // see R01
						d.timer = TRC_CYC - `SRPC_CNT_W'(1); // see R05
						d.row = q.row + ROW_W'(1); // see R03
						d.pulse = 1'b1;
					end else if (cif.cmd == SRPC_CMD_SREF) begin
						d.st = SRPC_SREF; // see R08
						d.timer = SREF_RELOAD;
						d.row = q.row + ROW_W'(1);
						d.pulse = 1'b1;
					end else if (!cke_i && !burst_active_i) begin
						d.st = SRPC_PDWN; // see R15
					end else if (!cke_i) begin
						d.suspend = 1'b1; // see R14
					end
				end else if (q.suspend && cke_i) begin
					d.suspend = 1'b0; // see R17
				end
			end
			SRPC_AREF: begin
				// Commands other than no-op are the controller's fault and are ignored
				if (q.timer == '0) begin
					d.st = SRPC_IDLE;
				end
			end
			SRPC_SREF: begin
				// Only clock enable is looked at here (see R09)
				if (cke_i) begin
					d.st = SRPC_AREF; // Finish any row in flight (see R12)
					d.timer = TRC_CYC - `SRPC_CNT_W'(1);
				end else if (q.timer == '0) begin
					d.timer = SREF_RELOAD; // see R10
					d.row = q.row + ROW_W'(1);
					d.pulse = 1'b1;
				end
			end
			SRPC_PDWN: begin
				if (cke_i) begin
					d.st = SRPC_IDLE; // see R17
				end
			end
			default: begin
				d.st = SRPC_IDLE;
			end
		endcase
		// Data mask only acts in the idle state
		for (int i = 0; i < LANES; i++) begin
			d.oe[i] = read_cycle_i && !dqm_i[i] && (d.st == SRPC_IDLE); // see R20 see R23
			d.wen[i] = write_cycle_i && !dqm_i[i] && (d.st == SRPC_IDLE); // see R19
		end
		// Status levels are registered so that every output leaves a flop
		d.clk_en = !d.suspend && !is_low_power(d.st); // see R14 see R17
		d.buf_en = !is_low_power(d.st); // see R15 see R17
		d.sref = (d.st == SRPC_SREF);
		d.pdwn = (d.st == SRPC_PDWN);
		d.busy = (d.st == SRPC_AREF);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= '{st: SRPC_IDLE, timer: '0, row: '0, cke_prev: 1'b1, suspend: 1'b0, pulse: 1'b0,
				oe: '0, wen: '0, clk_en: 1'b1, buf_en: 1'b1, sref: 1'b0, pdwn: 1'b0, busy: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign dq_oe_o = q.oe;
	assign wr_lane_en_o = q.wen;
	assign int_clk_en_o = q.clk_en;
	assign in_buf_en_o = q.buf_en;
	assign refresh_pulse_o = q.pulse;
	assign refresh_row_o = q.row;
	assign self_refresh_o = q.sref;
	assign power_down_o = q.pdwn;
	assign refresh_busy_o = q.busy;

	// =========================================
	// Checks
	sequence s_aref_cmd;
		q.st == SRPC_IDLE && q.cke_prev && !q.suspend && cif.cmd == SRPC_CMD_AREF;
	endsequence

	chk_aref_busy_len: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R05
		s_aref_cmd |=> refresh_busy_o [*3] ##1 !refresh_busy_o)
		else $error("auto refresh busy length wrong");

	chk_row_advance: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R03
		s_aref_cmd |=> refresh_row_o == $past(refresh_row_o) + ROW_W'(1) && refresh_pulse_o)
		else $error("refresh row did not advance");

	chk_sref_entry: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R08
		q.st == SRPC_IDLE && q.cke_prev && !q.suspend && cif.cmd == SRPC_CMD_SREF |=> self_refresh_o)
		else $error("self refresh not entered");

	chk_sref_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R09
		self_refresh_o && !cke_i |=> self_refresh_o)
		else $error("self refresh left while enable low");

	chk_pdwn_bufs: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R15
		power_down_o |-> !in_buf_en_o && !int_clk_en_o)
		else $error("buffers on in power-down");

	chk_pdwn_exit: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R17
		power_down_o && cke_i |=> !power_down_o ##0 in_buf_en_o)
		else $error("power-down exit failed");

	chk_deselect_ign: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R21
		q.st == SRPC_IDLE && cs_n_i && cke_i && q.cke_prev && !q.suspend |=> !refresh_busy_o && !self_refresh_o)
		else $error("deselect started an operation");

	chk_lowpwr_hiz: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R23
		(self_refresh_o || power_down_o) |-> dq_oe_o == '0)
		else $error("data driven in low power");

	chk_read_mask: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R20
		read_cycle_i && dqm_i[0] |=> !dq_oe_o[0])
		else $error("masked lane driven");

	// =========================================
	// Low-power checks
	sequence s_susp_cmd;
		q.st == SRPC_IDLE && q.cke_prev && !q.suspend && !cke_i && burst_active_i && cif.cmd != SRPC_CMD_SREF;
	endsequence

	sequence s_pdwn_cmd;
		q.st == SRPC_IDLE && q.cke_prev && !q.suspend && !cke_i && !burst_active_i && cif.cmd != SRPC_CMD_SREF;
	endsequence

	sequence s_sref_exit;
		self_refresh_o && cke_i;
	endsequence

	sequence s_busy_run;
		refresh_busy_o [*3] ##1 !refresh_busy_o;
	endsequence

	chk_susp_entry: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R14
		s_susp_cmd |=> !int_clk_en_o && in_buf_en_o && !power_down_o)
		else $error("clock not masked during burst");

	chk_susp_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R14
		!int_clk_en_o && in_buf_en_o && !cke_i |=> !int_clk_en_o)
		else $error("clock mask dropped early");

	chk_susp_exit: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R17
		!int_clk_en_o && in_buf_en_o && cke_i |=> int_clk_en_o)
		else $error("clock mask not lifted");

	chk_pdwn_entry: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R15
		s_pdwn_cmd |=> power_down_o && !in_buf_en_o)
		else $error("power-down not entered");

	chk_pdwn_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R15
		power_down_o && !cke_i |=> power_down_o)
		else $error("power-down left while enable low");

	chk_sref_bufs: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R09
		self_refresh_o |-> !in_buf_en_o && !int_clk_en_o && !refresh_busy_o)
		else $error("buffers on in self refresh");

	chk_sref_exit: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R17
		s_sref_exit |=> s_busy_run)
		else $error("self refresh exit run wrong");

	// =========================================
	// Refresh row, no-op and lane enable checks
	chk_pulse_single: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R05
		s_aref_cmd |=> refresh_pulse_o ##1 !refresh_pulse_o [*3])
		else $error("auto refresh pulsed more than once");

	chk_row_steady: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R03
		!refresh_pulse_o |-> $stable(refresh_row_o))
		else $error("refresh row moved without a refresh");

	chk_pulse_advance: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R10
		refresh_pulse_o |-> refresh_row_o == $past(refresh_row_o) + ROW_W'(1))
		else $error("refresh row step wrong");

	chk_nop_ign: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R22
		q.st == SRPC_IDLE && cif.cmd == SRPC_CMD_NOP && cke_i |=> !refresh_busy_o && !self_refresh_o && !refresh_pulse_o)
		else $error("no-op started an operation");

	chk_oe_read_only: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R20
		!read_cycle_i |=> dq_oe_o == '0)
		else $error("lane driven outside a read");

	chk_wen_write_only: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R19
		!write_cycle_i |=> wr_lane_en_o == '0)
		else $error("lane written outside a write");

	// =========================================
	// Data mask checks, one set per byte lane
	for (genvar g = 0; g < LANES; g++) begin : g_lane_chk
		chk_lane_write: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R19
			write_cycle_i && dqm_i[g] |=> !wr_lane_en_o[g])
			else $error("masked write lane enabled");

		chk_lane_read: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R20
			read_cycle_i && !dqm_i[g] && cke_i && q.st == SRPC_IDLE && cif.cmd != SRPC_CMD_AREF |=> dq_oe_o[g])
			else $error("unmasked read lane not driven");

		chk_lane_wr_en: assert property (@(posedge clk_i) disable iff (!reset_n_i) // see R19
			write_cycle_i && !dqm_i[g] && cke_i && q.st == SRPC_IDLE && cif.cmd != SRPC_CMD_AREF |=> wr_lane_en_o[g])
			else $error("unmasked write lane blocked");
	end

endmodule

/* src/srpc_params.svh */
`ifndef SRPC_PARAMS_SVH
`define SRPC_PARAMS_SVH

// Clock period in picoseconds (50 MHz)
`define SRPC_CLK_PERIOD_PS 20000
// Row cycle time, least, in picoseconds
`define SRPC_TRC_PS 60000
// Precharge time, least, in picoseconds
`define SRPC_TRP_PS 18000
// Cycles derived from the times, rounded up
`define SRPC_TRC_CYC ((`SRPC_TRC_PS + `SRPC_CLK_PERIOD_PS - 1) / `SRPC_CLK_PERIOD_PS)
`define SRPC_TRP_CYC ((`SRPC_TRP_PS + `SRPC_CLK_PERIOD_PS - 1) / `SRPC_CLK_PERIOD_PS)
// Self refresh internal interval: 64 ms / 4096 rows = 15625 ns
`define SRPC_SREF_INT_NS 15625
`define SRPC_SREF_INT_CYC ((`SRPC_SREF_INT_NS * 1000) / `SRPC_CLK_PERIOD_PS)
// Number of rows covered by the refresh counter
`define SRPC_ROWS 4096
`define SRPC_ROW_W 12
`define SRPC_LANES 4
`define SRPC_CNT_W 16

`endif

/* src/srpc_pkg.sv */
package srpc_pkg;

	typedef enum logic [3:0] {
		SRPC_IDLE = 4'b0001,
		SRPC_AREF = 4'b0010,
		SRPC_SREF = 4'b0100,
		SRPC_PDWN = 4'b1000
	} srpc_state_t;

	typedef enum logic [2:0] {
		SRPC_CMD_NONE = 3'h0,
		SRPC_CMD_NOP = 3'h1,
		SRPC_CMD_AREF = 3'h2,
		SRPC_CMD_SREF = 3'h3,
		SRPC_CMD_OTHER = 3'h4
	} srpc_cmd_t;

endpackage

/* src/srpc_cmd_if.sv */
`timescale 1ns/1ps
interface srpc_cmd_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic cke;
	srpc_pkg::srpc_cmd_t cmd;
	modport dec (input cs_n, input ras_n, input cas_n, input we_n, input cke, output cmd);
	modport ctl (output cs_n, output ras_n, output cas_n, output we_n, output cke, input cmd);
endinterface

/* src/srpc_cmd_dec.sv */
`timescale 1ns/1ps
module srpc_cmd_dec
	import srpc_pkg::*;
(
	srpc_cmd_if.dec c
);
	always_comb begin
		// Deselect blanks the decoder regardless of clock enable (see R21)
		if (c.cs_n) begin
			c.cmd = SRPC_CMD_NONE;
		end else if (c.ras_n && c.cas_n && c.we_n) begin
			c.cmd = SRPC_CMD_NOP; // see R22
		end else if (!c.ras_n && !c.cas_n && c.we_n) begin
			// Same code, clock enable picks auto or self refresh (see R01) (see R08)
			c.cmd = c.cke ? SRPC_CMD_AREF : SRPC_CMD_SREF;
		end else begin
			c.cmd = SRPC_CMD_OTHER;
		end
	end
endmodule

/* tb/srpc_ctl_model.sv */
`timescale 1ns/1ps
// ==========================================
// Controller model: drives command pins on the falling edge
module srpc_ctl_model (
	input wire logic clk_i,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic cke_o
);
	// Pin order in every task: {cs_n, ras_n, cas_n, we_n, cke}
	initial {cs_n_o, ras_n_o, cas_n_o, we_n_o, cke_o} = 5'h1f;
	task send(input logic [4:0] pins);
		@(negedge clk_i);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o, cke_o} = pins;
	endtask
	task aref();
		send(5'h03);
		send(5'h0f);
	endtask
	// Refreshes back to back, each spaced by row cycle plus precharge time
	task aref_burst(input int n);
		repeat (n) begin
			aref();
			repeat (2) send(5'h0f);
		end
	endtask
	task sref_enter();
		send(5'h02);
		send(5'h0e);
	endtask
	task sref_exit();
		send(5'h1f);
		repeat (3) send(5'h0f);
	endtask
endmodule

/* tb/sdram_refresh_power_control_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
	$display("unexpected %s expected %h seen %h", nm, exp, got); end end
module sdram_refresh_power_control_tb_top;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic cs_n, ras_n, cas_n, we_n, cke;
	logic burst_q = 1'b0;
	logic rd_q = 1'b0;
	logic wr_q = 1'b0;
	logic [3:0] dqm = 4'h0;
	logic [3:0] dq_oe, wr_en;
	logic clk_en, buf_en, pulse, sref, pdwn, busy;
	logic [11:0] row;
	int errors = 0;
	int comparisons = 0;
	int rows = 0;
	always #10 clk_i = ~clk_i;
	srpc_ctl_model i_ctl (.clk_i(clk_i), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .cke_o(cke));
	// Short self refresh interval keeps the run brief
	localparam int SREF_CYC = 8;
	srpc_core #(.SREF_INT_CYC(SREF_CYC)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n), .ras_n_i(ras_n),
		.cas_n_i(cas_n), .we_n_i(we_n), .cke_i(cke), .burst_active_i(burst_q), .read_cycle_i(rd_q),
		.write_cycle_i(wr_q), .dqm_i(dqm), .dq_oe_o(dq_oe), .wr_lane_en_o(wr_en), .int_clk_en_o(clk_en),
		.in_buf_en_o(buf_en), .refresh_pulse_o(pulse), .refresh_row_o(row), .self_refresh_o(sref),
		.power_down_o(pdwn), .refresh_busy_o(busy));
	// ==========================================
	// Common tasks
	task summarize();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Waits for a refresh pulse (sel 0) or self refresh exit (sel 1)
	task wait_on(input int sel);
		int n;
		n = 0;
		while ((sel == 0 ? pulse !== 1'b1 : sref !== 1'b0) && n < 50) begin
			@(negedge clk_i);
			n++;
		end
		if (sel == 0 ? pulse !== 1'b1 : sref !== 1'b0) begin
			errors++;
			summarize();
		end
	endtask
	// ==========================================
	// Scenarios
	task t_aref();
		repeat (2) begin
			i_ctl.aref();
			wait_on(0);
			rows++;
			`CHK("refresh row", 12'(rows), row)
			repeat (2) @(negedge clk_i);
			`CHK("busy held", 1'b1, busy)
			@(negedge clk_i);
			`CHK("busy done", 1'b0, busy)
		end
	endtask
	task t_ignored();
		logic [4:0] cmds [3] = '{5'h13, 5'h0f, 5'h09};
		foreach (cmds[i]) begin
			i_ctl.send(cmds[i]);
			@(negedge clk_i);
			`CHK("no pulse", 1'b0, pulse)
			`CHK("row kept", 12'(rows), row)
		end
	endtask
	task t_sref();
		int p;
		int last;
		p = 0;
		last = 0;
		i_ctl.aref_burst(4);
		rows += 4;
		`CHK("rows before entry", 12'(rows), row)
		i_ctl.sref_enter();
		`CHK("in self refresh", 1'b1, sref)
		`CHK("buffers off", 1'b0, buf_en)
		`CHK("entry refresh", 1'b1, pulse)
		rd_q = 1'b1;
		for (int k = 1; k <= 30; k++) begin
			@(negedge clk_i);
			if (pulse === 1'b1) begin
				`CHK("refresh interval", SREF_CYC, k - last)
				last = k;
				p++;
			end
		end
		`CHK("internal refreshes", 30 / SREF_CYC, p)
		`CHK("bus quiet", 4'h0, dq_oe)
		rd_q = 1'b0;
		i_ctl.sref_exit();
		wait_on(1);
		`CHK("buffers back", 1'b1, buf_en)
		rows += p + 1;
		`CHK("rows after exit", 12'(rows), row)
		i_ctl.aref_burst(4);
		rows += 4;
		`CHK("rows after burst", 12'(rows), row)
	endtask
	task t_pdwn_susp();
		i_ctl.send(5'h0e);
		@(negedge clk_i);
		`CHK("power down", 1'b1, pdwn)
		`CHK("buffers off", 1'b0, buf_en)
		i_ctl.send(5'h0f);
		@(negedge clk_i);
		`CHK("power up", 2'b01, {pdwn, buf_en})
		burst_q = 1'b1;
		i_ctl.send(5'h0e);
		@(negedge clk_i);
		`CHK("clock masked", 2'b00, {clk_en, pdwn})
		i_ctl.send(5'h0f);
		@(negedge clk_i);
		`CHK("clock back", 1'b1, clk_en)
		burst_q = 1'b0;
	endtask
	task t_mask();
		wr_q = 1'b1;
		dqm = 4'h5;
		@(negedge clk_i);
		`CHK("write lanes", 4'ha, wr_en)
		wr_q = 1'b0;
		rd_q = 1'b1;
		dqm = 4'h3;
		@(negedge clk_i);
		`CHK("read lanes", 4'hc, dq_oe)
		rd_q = 1'b0;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		reset_n_i = 1'b1;
		`CHK("reset outputs", 4'hc, {clk_en, buf_en, sref, busy})
		t_aref();
		t_ignored();
		t_mask();
		t_pdwn_susp();
		t_sref();
		summarize();
	end
endmodule
